// >>> tmr_consts.svh
// Constants for the 16-bit timer: register offsets, field positions,
// reset values and fixed count limits. Assumes byte-wide registers
// placed one per aligned 32-bit word on the register bus.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMR_OFS_CTL_A 8'h00
`define TMR_OFS_CTL_B 8'h04
`define TMR_OFS_CNT_LO 8'h08
`define TMR_OFS_CNT_HI 8'h0C
`define TMR_OFS_CAP_LO 8'h10
`define TMR_OFS_CAP_HI 8'h14
`define TMR_OFS_CMPA_LO 8'h18
`define TMR_OFS_CMPA_HI 8'h1C
`define TMR_OFS_CMPB_LO 8'h20
`define TMR_OFS_CMPB_HI 8'h24
`define TMR_OFS_FLAGS 8'h28
`define TMR_OFS_IRQ_EN 8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR_BIT_OVF 0
`define TMR_BIT_CAP 1
`define TMR_BIT_CAP_SRC 5
`define TMR_BIT_CAP_RISE 6

// ----------------------------------------------------------------
// Reset values, responses, tick selects, modes and count limits
// ----------------------------------------------------------------
`define TMR_RST_BYTE 8'h00
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`define TMR_CS_STOP 3'h0
`define TMR_CS_SYSCLK 3'h1
`define TMR_MODE_NORMAL 4'h0
`define TMR_MODE_CTC_A 4'h4
`define TMR_MODE_CTC_ICR 4'hC
`define TMR_TOP_8BIT 16'h00FF
`define TMR_TOP_9BIT 16'h01FF
`define TMR_TOP_10BIT 16'h03FF
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hFFFF
`define TMR_ONE 16'h0001

`endif

// >>> tmr_pkg.sv
// Types shared by the timer core and its capture front end.
// Assumes tmr_consts.svh is compiled alongside.
package tmr_pkg;

  // ----------------------------------------------------------------
  // Count direction, Gray ordered
  // ----------------------------------------------------------------
  typedef enum logic {
    TMR_DIR_UP = 1'b0,
    TMR_DIR_DOWN = 1'b1
  } tmr_dir_type;

  // ----------------------------------------------------------------
  // Core state: registers and bus channel state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl_a;      // Mode low bits
    logic [7:0] ctl_b;      // Tick select, mode high bits, capture setup
    logic [15:0] cnt;       // Counter
    logic [15:0] cap;       // Capture value
    logic [15:0] cmp_a;     // Compare value A
    logic [15:0] cmp_b;     // Compare value B
    logic [7:0] temp;       // Shared high-byte holding register
    logic ovf;              // Overflow flag
    logic capf;             // Capture flag
    logic ovf_ie;           // Overflow interrupt enable
    logic cap_ie;           // Capture interrupt enable
    tmr_dir_type dir;       // Dual-slope direction
    logic aw_held;          // Write address accepted
    logic [7:0] aw_addr;    // Held write address
    logic w_held;           // Write data accepted
    logic [7:0] w_data;     // Held write data
    logic w_lane;           // Low byte lane strobe
    logic bvalid;           // Write response pending
    logic [1:0] bresp;      // Write response code
    logic rvalid;           // Read data pending
    logic [7:0] rdata;      // Read data
    logic [1:0] rresp;      // Read response code
  } tmr_state_type;

  // ----------------------------------------------------------------
  // Capture front end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_s1;           // Pin synchroniser stage one
    logic pin_s2;           // Pin synchroniser stage two
    logic cmp_s1;           // Comparator synchroniser stage one
    logic cmp_s2;           // Comparator synchroniser stage two
    logic prev;             // Last selected level
  } tmr_cap_state_type;

endpackage

// >>> tmr_capture_if.sv
// Link between the timer core and its capture front end.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface tmr_capture_if;
  logic use_comparator;  // Select comparator instead of pin
  logic rising;          // Trigger on rising edge when high
  logic enable;          // Capture input active
  logic event_pulse;     // One-cycle trigger

  modport core (output use_comparator, output rising, output enable, input event_pulse);
  modport unit (input use_comparator, input rising, input enable, output event_pulse);
endinterface

// >>> tmr_capture.sv
// Capture front end: synchronises the capture pin and comparator
// output, selects one and detects the configured edge.
// Assumes asynchronous inputs and one system clock.
`timescale 1ns/100ps
module tmr_capture
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic capture_pin,
  input wire logic comparator_output,
  tmr_capture_if.unit cap_if
);

  tmr_cap_state_type q;  // Registered state
  tmr_cap_state_type d;  // Next state
  logic level;           // Selected synchronised level

  // ----------------------------------------------------------------
  // Next state and edge detect
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.pin_s1 = capture_pin;
    d.pin_s2 = q.pin_s1;
    d.cmp_s1 = comparator_output;
    d.cmp_s2 = q.cmp_s1;
    level = cap_if.use_comparator ? q.cmp_s2 : q.pin_s2;
    d.prev = level;
  end

  // Edge matching the configured polarity; source swaps may trigger too
  assign cap_if.event_pulse = cap_if.enable && (level != q.prev) && (level == cap_if.rising);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // tmr_capture

// >>> tmr_timer16.sv
// 16-bit up/down timer with input capture and byte-wide access
// through a shared holding register, on an AXI4-Lite slave.
// Assumes tick_sources comes from a prescaler on the same clock.
// Behaviour
// - Holding register keeps value until overwritten.
// - Tick select field picks tick; zero stops.
// - Counter clears, counts up or down per tick.
// - Low-byte access moves upper byte via holding.
// - Host counter write beats clear or count.
// - Four-bit mode field spans both control registers.
// - Indicate TOP and BOTTOM of the sequence.
// - Overflow flag set per mode, requests interrupt.
// - Configured edge copies counter into capture, except in modes using it as TOP.
// - Capture flag sets with the copy.
// - Enabled capture flag requests interrupt; service clears.
// - Writing one clears capture flag; zero keeps.
// - Capture low read loads holding for upper.
// - Capture writable only in modes using it as TOP.
// - One holding register shared; low byte transfers.
// - Compare reads bypass the holding register.
// - BOTTOM at 0x0000, MAX at 0xFFFF.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_timer16
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] tick_sources,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  output logic overflow_irq,
  output logic capture_irq,
  output logic [15:0] count_value,
  output logic [15:0] compare_value_a,
  output logic [15:0] compare_value_b,
  output logic at_top,
  output logic at_bottom,
  output logic at_max
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tmr_state_type q;         // Registered state
  tmr_state_type d;         // Next state
  tmr_capture_if cap_if (); // Link to capture front end
  logic [3:0] mode;         // Waveform mode field
  logic [2:0] tick_sel;     // Tick source select
  logic tick;               // Selected timer tick
  logic [15:0] top_val;     // Highest value of the sequence
  logic dual_slope;         // Up/down counting modes
  logic clear_at_top;       // Clear-on-match modes
  logic fast_mode;          // Single-slope wrap at TOP modes
  logic icr_top;            // Capture register is TOP
  logic wr_go;              // Write performed this cycle
  logic wr_en;              // Write with the low lane strobed
  logic rd_go;              // Read taken this cycle
  logic rd_mapped;          // Read address decodes
  logic wr_mapped;          // Write address decodes
  logic [7:0] rd_byte;      // Read data byte

  // ----------------------------------------------------------------
  // Capture front end
  // ----------------------------------------------------------------
  tmr_capture u_capture (
    .clk(clk),
    .reset_n(reset_n),
    .capture_pin(capture_pin),
    .comparator_output(comparator_output),
    .cap_if(cap_if)
  );

  // Capture setup from control B; idle while capture is TOP
  assign cap_if.use_comparator = q.ctl_b[`TMR_BIT_CAP_SRC];
  assign cap_if.rising = q.ctl_b[`TMR_BIT_CAP_RISE];
  assign cap_if.enable = !icr_top;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign mode = {q.ctl_b[4:3], q.ctl_a[1:0]};
  assign tick_sel = q.ctl_b[2:0];

  // Tick select: stop, every clock, or prescaler taps
  assign tick = (tick_sel == `TMR_CS_STOP) ? 1'b0 :
      ((tick_sel == `TMR_CS_SYSCLK) ? 1'b1 : tick_sources[tick_sel]);

  // TOP value and counting class per mode
  always_comb begin
    dual_slope = 1'b0;
    fast_mode = 1'b0;
    clear_at_top = (mode == `TMR_MODE_CTC_A) || (mode == `TMR_MODE_CTC_ICR);
    icr_top = 1'b0;
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: fast_mode = 1'b1;
      default: fast_mode = 1'b0;  // Normal, clear-on-match and reserved
    endcase
    case (mode)
      4'h1, 4'h5: top_val = `TMR_TOP_8BIT;
      4'h2, 4'h6: top_val = `TMR_TOP_9BIT;
      4'h3, 4'h7: top_val = `TMR_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_val = q.cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: begin
        top_val = q.cap;
        icr_top = 1'b1;
      end
      default: begin
        top_val = `TMR_MAX;  // Normal and reserved modes
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshakes and decode
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready = !q.w_held;
  assign s_axi_arready = !q.rvalid;
  assign wr_go = q.aw_held && q.w_held && !q.bvalid;
  assign wr_en = wr_go && q.w_lane && wr_mapped;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Write address check
  assign wr_mapped = q.aw_addr inside {`TMR_OFS_CTL_A, `TMR_OFS_CTL_B, `TMR_OFS_CNT_LO, `TMR_OFS_CNT_HI,
      `TMR_OFS_CAP_LO, `TMR_OFS_CAP_HI, `TMR_OFS_CMPA_LO, `TMR_OFS_CMPA_HI,
      `TMR_OFS_CMPB_LO, `TMR_OFS_CMPB_HI, `TMR_OFS_FLAGS, `TMR_OFS_IRQ_EN};

  // Read data mux; upper counter and capture bytes come from holding
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      `TMR_OFS_CTL_A: rd_byte = q.ctl_a;
      `TMR_OFS_CTL_B: rd_byte = q.ctl_b;
      `TMR_OFS_CNT_LO: rd_byte = q.cnt[7:0];
      `TMR_OFS_CNT_HI: rd_byte = q.temp;
      `TMR_OFS_CAP_LO: rd_byte = q.cap[7:0];
      `TMR_OFS_CAP_HI: rd_byte = q.temp;
      `TMR_OFS_CMPA_LO: rd_byte = q.cmp_a[7:0];
      `TMR_OFS_CMPA_HI: rd_byte = q.cmp_a[15:8];
      `TMR_OFS_CMPB_LO: rd_byte = q.cmp_b[7:0];
      `TMR_OFS_CMPB_HI: rd_byte = q.cmp_b[15:8];
      `TMR_OFS_FLAGS: rd_byte = {6'h00, q.capf, q.ovf};
      `TMR_OFS_IRQ_EN: rd_byte = {6'h00, q.cap_ie, q.ovf_ie};
      default: begin
        rd_byte = `TMR_RST_BYTE;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata[7:0];
      d.w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_mapped ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end
    // Read channel and low-byte read side effects
    if (s_axi_rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata = rd_byte;
      d.rresp = rd_mapped ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      if (s_axi_araddr == `TMR_OFS_CNT_LO) d.temp = q.cnt[15:8];
      if (s_axi_araddr == `TMR_OFS_CAP_LO) d.temp = q.cap[15:8];
    end
    // Counting on tick
    if (tick) begin
      if (dual_slope) begin
        if (q.dir == TMR_DIR_UP) begin
          if (q.cnt >= top_val) begin
            d.dir = TMR_DIR_DOWN;
            d.cnt = q.cnt - `TMR_ONE;
          end else begin
            d.cnt = q.cnt + `TMR_ONE;
          end
        end else begin
          if (q.cnt == `TMR_BOTTOM) begin
            d.dir = TMR_DIR_UP;
            d.cnt = q.cnt + `TMR_ONE;
          end else begin
            d.cnt = q.cnt - `TMR_ONE;
          end
        end
      end else if ((clear_at_top || fast_mode) && (q.cnt == top_val)) begin
        d.cnt = `TMR_BOTTOM;
      end else begin
        d.cnt = q.cnt + `TMR_ONE;
      end
    end
    // Capture of the counter
    if (cap_if.event_pulse) d.cap = q.cnt;
    // Register writes; holding kept until overwritten
    if (wr_en) begin
      case (q.aw_addr)
        `TMR_OFS_CTL_A: d.ctl_a = q.w_data;
        `TMR_OFS_CTL_B: d.ctl_b = q.w_data;
        `TMR_OFS_CNT_HI, `TMR_OFS_CAP_HI, `TMR_OFS_CMPA_HI, `TMR_OFS_CMPB_HI: d.temp = q.w_data;
        `TMR_OFS_CNT_LO: d.cnt = {q.temp, q.w_data};
        `TMR_OFS_CAP_LO: if (icr_top) d.cap = {q.temp, q.w_data};
        `TMR_OFS_CMPA_LO: d.cmp_a = {q.temp, q.w_data};
        `TMR_OFS_CMPB_LO: d.cmp_b = {q.temp, q.w_data};
        `TMR_OFS_FLAGS: begin
          d.ovf = q.ovf && !q.w_data[`TMR_BIT_OVF];
          d.capf = q.capf && !q.w_data[`TMR_BIT_CAP];
        end
        `TMR_OFS_IRQ_EN: begin
          d.ovf_ie = q.w_data[`TMR_BIT_OVF];
          d.cap_ie = q.w_data[`TMR_BIT_CAP];
        end
        default: begin
        end
      endcase
    end
    // Interrupt service clears
    if (overflow_irq_ack) d.ovf = 1'b0;
    if (capture_irq_ack) d.capf = 1'b0;
    // Flag sets win over any clear
    if (tick && !dual_slope && (fast_mode ? (q.cnt == top_val) : (q.cnt == `TMR_MAX))) d.ovf = 1'b1;
    if (tick && dual_slope && (q.dir == TMR_DIR_DOWN) && (q.cnt == `TMR_ONE)) d.ovf = 1'b1;
    if (cap_if.event_pulse) d.capf = 1'b1;
  end

  // ----------------------------------------------------------------
  // State register; everything zero out of reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign overflow_irq = q.ovf && q.ovf_ie;
  assign capture_irq = q.capf && q.cap_ie;
  assign count_value = q.cnt;
  assign compare_value_a = q.cmp_a;
  assign compare_value_b = q.cmp_b;
  assign at_top = (q.cnt == top_val);
  assign at_bottom = (q.cnt == `TMR_BOTTOM);
  assign at_max = (q.cnt == `TMR_MAX);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence seq_cnt_lo_write;
    wr_en && (q.aw_addr == `TMR_OFS_CNT_LO);
  endsequence
  sequence seq_cnt_lo_read;
    rd_go && (s_axi_araddr == `TMR_OFS_CNT_LO)
      && !(wr_en && (q.aw_addr inside {`TMR_OFS_CNT_HI, `TMR_OFS_CAP_HI, `TMR_OFS_CMPA_HI, `TMR_OFS_CMPB_HI}));
  endsequence
  sequence seq_quiet_tick;
    tick && !wr_en && (mode == `TMR_MODE_NORMAL);
  endsequence

  chk_stop_holds: assert property ((tick_sel == `TMR_CS_STOP) && !wr_en |=> $stable(q.cnt))
    else $error("counter moved while stopped");
  chk_write_wins: assert property (seq_cnt_lo_write |=> (q.cnt == {$past(q.temp), $past(q.w_data)}))
    else $error("host counter write lost");
  chk_count_step: assert property (seq_quiet_tick ##0 (q.cnt != `TMR_MAX) |=> q.cnt == $past(q.cnt) + `TMR_ONE)
    else $error("counter did not step by one");
  chk_ovf_at_max: assert property (seq_quiet_tick ##0 (q.cnt == `TMR_MAX) |=> q.ovf && (q.cnt == `TMR_BOTTOM))
    else $error("overflow missing at wrap");
  chk_capture_copy: assert property (cap_if.event_pulse |=> q.capf && (q.cap == $past(q.cnt)))
    else $error("capture copy or flag wrong");
  chk_flag_w1c: assert property (wr_en && (q.aw_addr == `TMR_OFS_FLAGS) && q.w_data[`TMR_BIT_CAP]
      && !cap_if.event_pulse |=> !q.capf)
    else $error("capture flag not cleared");
  chk_temp_load: assert property (seq_cnt_lo_read |=> q.temp == $past(q.cnt[15:8]))
    else $error("holding not loaded on low read");
  chk_temp_hold: assert property (!rd_go && !wr_en |=> $stable(q.temp))
    else $error("holding register changed");
  chk_cap_guard: assert property (!icr_top && !cap_if.event_pulse |=> $stable(q.cap))
    else $error("capture changed without event");
  chk_read_answer: assert property (rd_go |=> s_axi_rvalid ##0 (s_axi_rdata[7:0] == $past(rd_byte)))
    else $error("read answer late or wrong");

endmodule // tmr_timer16

// >>> tmr_host.sv
// Host model: processor core on the register bus, one access at a time.
// Assumes the slave shares clk; bus waits end only by the bench timeout.
`timescale 1ns/100ps
module tmr_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ------------------------------------------------------------
  // Idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    {awaddr, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'h1;
  end
  // Byte write; single caller so pairs never interleave
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Byte read; arvalid held until arready is sampled, then waits for rvalid
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // tmr_host

// >>> tb_top.sv
// Self-checking bench for the 16-bit timer with capture.
// Assumes tmr_host drives the register bus; bench drives ticks and pins.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tb_top;
  import tmr_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, pin = 1'b0, cmp = 1'b0, oack = 1'b0, cack = 1'b0;
  logic [7:0] ticks = 8'h00, awa, ara;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, oirq, cirq, atop, abot, amax;
  logic [31:0] wd, rdt;
  logic [3:0] ws;
  logic [1:0] bre, rre;
  logic [15:0] cnt, cpa, cpb, v, hold;
  logic [31:0] seed = 32'h3DAF;
  int err_total = 0, num_checks = 0, m_cap = 0;
  logic [7:0] cfg [3] = '{8'h40, 8'h00, 8'h60};
  always #10 clk = ~clk;
  tmr_host h (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
    .wvalid(wv), .wready(wrd), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
    .arready(arr), .rdata(rdt), .rresp(rre), .rvalid(rv), .rready(rr));
  tmr_timer16 DUT (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .tick_sources(ticks), .capture_pin(pin), .comparator_output(cmp), .overflow_irq_ack(oack),
    .capture_irq_ack(cack), .overflow_irq(oirq), .capture_irq(cirq), .count_value(cnt),
    .compare_value_a(cpa), .compare_value_b(cpb), .at_top(atop), .at_bottom(abot), .at_max(amax));
  // ------------------------------------------------------------
  // Random source, compare and bus helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    h.wr(a, d, r);
    chk("bresp", 16'h0, {14'h0, r});
  endtask
  task automatic w16(input logic [7:0] a, input logic [15:0] d);
    w(a + 8'h04, d[15:8]);
    w(a, d[7:0]);
  endtask
  task automatic r8(input logic [7:0] a, input logic [7:0] e);
    logic [1:0] r;
    logic [7:0] d;
    h.rd(a, d, r);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask
  task automatic r16(input logic [7:0] a, input logic [15:0] e);
    r8(a, e[7:0]);
    r8(a + 8'h04, e[15:8]);
  endtask
  // Tick pulses on source 2, then settle to the falling edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) ticks <= 8'h04;
      @(posedge clk) ticks <= 8'h00;
    end
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    r16(`TMR_OFS_CNT_LO, 16'h0);
    r16(`TMR_OFS_CAP_LO, 16'h0);
    r8(`TMR_OFS_FLAGS, 8'h00);
    chk("bottom", 16'h1, {15'h0, abot});
    $display("reset test done");
    v = xs();
    w16(`TMR_OFS_CNT_LO, v);
    tick(2);
    chk("stopped", v, cnt);
    r16(`TMR_OFS_CNT_LO, v);
    hold = v ^ 16'hA500;
    w16(`TMR_OFS_CMPA_LO, hold);
    chk("cmpa", hold, cpa);
    w(`TMR_OFS_CMPB_LO, 8'h3C);
    chk("cmpb", {hold[15:8], 8'h3C}, cpb);
    r8(`TMR_OFS_CNT_LO, v[7:0]);
    r8(`TMR_OFS_CMPA_HI, hold[15:8]);
    r8(`TMR_OFS_CNT_HI, v[15:8]);
    h.rd(8'h30, v[7:0], v[9:8]);
    chk("rresp", 16'h2, {14'h0, v[9:8]});
    $display("access test done");
    w16(`TMR_OFS_CNT_LO, 16'hFFFE);
    w(`TMR_OFS_CTL_B, 8'h02);
    tick(1);
    chk("max", 16'h3, {14'h0, amax, atop});
    tick(2);
    chk("count", 16'h0001, cnt);
    r8(`TMR_OFS_FLAGS, 8'h01);
    w(`TMR_OFS_IRQ_EN, 8'h03);
    chk("ovf_irq", 16'h1, {15'h0, oirq});
    @(posedge clk) oack <= 1'b1;
    @(posedge clk) oack <= 1'b0;
    r8(`TMR_OFS_FLAGS, 8'h00);
    w(`TMR_OFS_CTL_B, 8'h00);
    tick(2);
    chk("halt", 16'h0001, cnt);
    // Dual slope, fixed TOP of 00FF: turn at TOP, overflow on reaching zero
    w16(`TMR_OFS_CNT_LO, 16'h00FE);
    w(`TMR_OFS_CTL_A, 8'h01);
    w(`TMR_OFS_CTL_B, 8'h02);
    tick(1);
    chk("dual_top", 16'h1, {15'h0, atop});
    tick(1);
    chk("dual_down", 16'h00FE, cnt);
    w16(`TMR_OFS_CNT_LO, 16'h0001);
    tick(1);
    chk("dual_bottom", 16'h1, {15'h0, abot});
    r8(`TMR_OFS_FLAGS, 8'h01);
    w(`TMR_OFS_FLAGS, 8'h01);
    w(`TMR_OFS_CTL_B, 8'h00);
    w(`TMR_OFS_CTL_A, 8'h00);
    $display("count test done");
    foreach (cfg[i]) begin
      m_cap = xs();
      w16(`TMR_OFS_CNT_LO, m_cap[15:0]);
      w(`TMR_OFS_CTL_B, cfg[i]);
      @(posedge clk);
      if (i == 2) cmp <= 1'b1;
      else pin <= ~pin;
      repeat (8) @(posedge clk);
      r16(`TMR_OFS_CAP_LO, m_cap[15:0]);
      w(`TMR_OFS_FLAGS, 8'h00);
      r8(`TMR_OFS_FLAGS, 8'h02);
      chk("cap_irq", 16'h1, {15'h0, cirq});
      if (i == 1) begin
        @(posedge clk) cack <= 1'b1;
        @(posedge clk) cack <= 1'b0;
      end else w(`TMR_OFS_FLAGS, 8'h02);
      r8(`TMR_OFS_FLAGS, 8'h00);
    end
    v = xs();
    w16(`TMR_OFS_CAP_LO, v);
    r16(`TMR_OFS_CAP_LO, m_cap[15:0]);
    w(`TMR_OFS_CTL_B, 8'h18);
    w16(`TMR_OFS_CAP_LO, v);
    r16(`TMR_OFS_CAP_LO, v);
    $display("capture test done");
    finish_test();
  end
endmodule // tb_top
